/* File: core/aecr_defines.svh */
// register offsets, field positions and reset values of the aec status and sequencer bank
// assumes word-indexed offsets; byte address is four times the index
`ifndef AECR_DEFINES_SVH
`define AECR_DEFINES_SVH

`define AECR_IDX_SPARE_B3     8'hB3
`define AECR_IDX_SPARE_B4     8'hB4
`define AECR_IDX_SPARE_B5     8'hB5
`define AECR_IDX_PIXCNT_LO    8'hB8
`define AECR_IDX_PIXCNT_HI    8'hB9
`define AECR_IDX_MEAN         8'hBA
`define AECR_IDX_INTEG        8'hBB
`define AECR_IDX_AMP          8'hBC
`define AECR_IDX_SPARE_BD     8'hBD
`define AECR_IDX_SEQ_CTRL     8'hC0
`define AECR_IDX_MULT         8'hC7
`define AECR_IDX_IRQ_STAT     8'hE0
`define AECR_IDX_IRQ_MASK     8'hE1
`define AECR_IDX_EXPO_LEN     8'hE2

`define AECR_RST_SPARE_B3     16'h00AA
`define AECR_RST_SPARE_B4     16'h0100
`define AECR_RST_SPARE_B5     16'h0155
`define AECR_RST_SEQ_CTRL     16'h0000
`define AECR_RST_MULT         16'h0001
`define AECR_RST_EXPO_LEN     16'h0010

`define AECR_SEQ_ENABLE_BIT   0
`define AECR_SEQ_ROLLING_BIT  1
`define AECR_SEQ_TRIG_BIT     4
`define AECR_SEQ_SLAVE_BIT    5
`define AECR_SEQ_CTRL_MASK    16'h0033
`define AECR_MEAN_LOCK_BIT    12

`define AECR_IRQ_LOCK_BIT     0
`define AECR_IRQ_EXPO_BIT     1
`define AECR_IRQ_STAT_UPD_BIT 2
`define AECR_IRQ_WIDTH        3

`define AECR_RESP_OKAY        2'b00
`define AECR_RESP_SLVERR      2'b10

`endif

/* File: core/aecr_pkg.sv */
// types for the aec status and sequencer register bank
// assumes aecr_defines.svh is available for constants
package aecr_pkg;

  typedef struct packed {
    logic [18:0] pix_count;
    logic [9:0]  mean_level;
    logic        locked;
    logic [15:0] integration;
    logic [1:0]  first_analog_amp_step;
    logic [1:0]  second_analog_amp_step;
    logic [11:0] digital_gain;
  } aecr_stats_s;

  typedef struct packed {
    logic enable;
    logic rolling;
    logic triggered;
    logic slave;
  } aecr_mode_s;

  typedef enum logic [1:0] {
    AECR_SEQ_IDLE,
    AECR_SEQ_EXPOSE,
    AECR_SEQ_WAIT_TRIG
  } aecr_seq_e;

endpackage

/* File: core/aecr_regs.sv */
// aec statistics readback and sequencer configuration bank on axi4-lite
// assumes aec loop statistics on the same clock; trigger and sync pins asynchronous
// Overview of operation
// [RQ1] Sampled pixel count bits 15:0 read from the low count word.
// [RQ2] Count bits 18:16 read in bits 2:0 of the next word, nineteen bits in all.
// [RQ3] Mean level reads in bits 9:0 and the filter lock flag in bit 12.
// [RQ4] Gain readback: first stage 1:0, second stage 3:2, digital gain 15:4 in 5.7.
// [RQ5] Control bit 0 low keeps the sequencer idle, high runs it; resets low.
// [RQ6] Control bit 1 low selects global shutter, high rolling shutter; resets low.
// [RQ7] In global shutter, control bit 4 selects normal (0) or triggered (1) timing.
// [RQ8] In global shutter, control bit 5 selects master (0) or slave (1) timing.
// [RQ9] Global shutter exposure counts units of the multiplier times one clock period.
// [RQ10] Writes to the read-only status words are ignored.
// [RQ11] Triggered and slave selections are ignored while rolling shutter is chosen.
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/100ps
`include "aecr_defines.svh"

module aecr_regs (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic [11:0]          s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [11:0]          s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire aecr_pkg::aecr_stats_s stats,
  input  wire logic                 trigger_pin,
  input  wire logic                 frame_sync_pin,
  output logic                      seq_running,
  output logic                      seq_rolling,
  output logic                      seq_triggered,
  output logic                      seq_slave,
  output logic                      expose_active,
  output logic                      irq
);

  logic [15:0]               spare_b3_q, spare_b4_q, spare_b5_q;
  logic [15:0]               seq_ctrl_q;
  logic [15:0]               mult_q;
  logic [15:0]               expo_len_q;
  logic [`AECR_IRQ_WIDTH-1:0] irq_stat_q;
  logic [`AECR_IRQ_WIDTH-1:0] irq_mask_q;
  logic [`AECR_IRQ_WIDTH-1:0] irq_clr;
  logic [`AECR_IRQ_WIDTH-1:0] irq_evt;
  logic                      aw_held_q, w_held_q;
  logic [11:0]               awaddr_q;
  logic [31:0]               wdata_q;
  logic [3:0]                wstrb_q;
  logic                      wr_fire;
  logic [9:0]                wr_idx;
  logic [15:0]               wr_val;
  logic                      wr_ok;
  logic [9:0]                rd_idx;
  logic [15:0]               rd_val;
  logic                      rd_ok;
  logic [2:0]                trig_sync_q, fsync_sync_q;
  logic                      trig_q, fsync_q, trig_rise;
  logic                      lock_q;
  logic [15:0]               integ_q;
  aecr_pkg::aecr_mode_s      mode;
  aecr_pkg::aecr_seq_e       seq_q;
  logic                      tmr_start, tmr_done;

  // effective mode; trigger and slave only apply in global shutter
  always_comb begin
    mode.enable    = seq_ctrl_q[`AECR_SEQ_ENABLE_BIT];  // RQ5
    mode.rolling   = seq_ctrl_q[`AECR_SEQ_ROLLING_BIT]; // RQ6
    mode.triggered = seq_ctrl_q[`AECR_SEQ_TRIG_BIT] &
                     ~seq_ctrl_q[`AECR_SEQ_ROLLING_BIT]; // RQ7 RQ11
    mode.slave     = seq_ctrl_q[`AECR_SEQ_SLAVE_BIT] &
                     ~seq_ctrl_q[`AECR_SEQ_ROLLING_BIT]; // RQ8 RQ11
  end

  // write channel: address and data taken in either order
  assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;
  assign wr_idx  = awaddr_q[11:2];
  assign wr_val  = {wstrb_q[1] ? wdata_q[15:8] : 8'h00, wstrb_q[0] ? wdata_q[7:0] : 8'h00};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q     <= 1'b0;
      w_held_q      <= 1'b0;
      awaddr_q      <= 12'h000;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `AECR_RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held_q && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= !w_held_q && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q     <= 1'b1;
        awaddr_q      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q     <= 1'b1;
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_held_q    <= 1'b0;
        w_held_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `AECR_RESP_OKAY : `AECR_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // write decode; status words accept and drop the data
  always_comb begin
    wr_ok   = 1'b1;
    irq_clr = '0;
    if (wr_idx == {2'b00, `AECR_IDX_PIXCNT_LO} || wr_idx == {2'b00, `AECR_IDX_PIXCNT_HI} ||
        wr_idx == {2'b00, `AECR_IDX_MEAN} || wr_idx == {2'b00, `AECR_IDX_INTEG} ||
        wr_idx == {2'b00, `AECR_IDX_AMP} || wr_idx == {2'b00, `AECR_IDX_SPARE_BD}) begin
      wr_ok = 1'b1; // RQ10
    end else if (wr_idx == {2'b00, `AECR_IDX_IRQ_STAT}) begin
      irq_clr = wr_fire ? wr_val[`AECR_IRQ_WIDTH-1:0] : '0;
    end else if (wr_idx == {2'b00, `AECR_IDX_SPARE_B3} || wr_idx == {2'b00, `AECR_IDX_SPARE_B4} ||
                 wr_idx == {2'b00, `AECR_IDX_SPARE_B5} || wr_idx == {2'b00, `AECR_IDX_SEQ_CTRL} ||
                 wr_idx == {2'b00, `AECR_IDX_MULT} || wr_idx == {2'b00, `AECR_IDX_IRQ_MASK} ||
                 wr_idx == {2'b00, `AECR_IDX_EXPO_LEN}) begin
      wr_ok = 1'b1;
    end else begin
      wr_ok = 1'b0;
    end
  end

  // software-written registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      spare_b3_q <= `AECR_RST_SPARE_B3;
      spare_b4_q <= `AECR_RST_SPARE_B4;
      spare_b5_q <= `AECR_RST_SPARE_B5;
      seq_ctrl_q <= `AECR_RST_SEQ_CTRL; // RQ5 RQ6
      mult_q     <= `AECR_RST_MULT;
      expo_len_q <= `AECR_RST_EXPO_LEN;
      irq_mask_q <= '0;
    end else if (wr_fire) begin
      if (wr_idx == {2'b00, `AECR_IDX_SPARE_B3}) begin
        spare_b3_q <= wr_val;
      end else if (wr_idx == {2'b00, `AECR_IDX_SPARE_B4}) begin
        spare_b4_q <= wr_val;
      end else if (wr_idx == {2'b00, `AECR_IDX_SPARE_B5}) begin
        spare_b5_q <= wr_val;
      end else if (wr_idx == {2'b00, `AECR_IDX_SEQ_CTRL}) begin
        seq_ctrl_q <= wr_val & `AECR_SEQ_CTRL_MASK;
      end else if (wr_idx == {2'b00, `AECR_IDX_MULT}) begin
        mult_q <= wr_val;
      end else if (wr_idx == {2'b00, `AECR_IDX_EXPO_LEN}) begin
        expo_len_q <= wr_val;
      end else if (wr_idx == {2'b00, `AECR_IDX_IRQ_MASK}) begin
        irq_mask_q <= wr_val[`AECR_IRQ_WIDTH-1:0];
      end
    end
  end

  // read decode
  assign rd_idx = s_axi_araddr[11:2];

  always_comb begin
    rd_ok  = 1'b1;
    rd_val = 16'h0000;
    if (rd_idx == {2'b00, `AECR_IDX_SPARE_B3}) begin
      rd_val = spare_b3_q;
    end else if (rd_idx == {2'b00, `AECR_IDX_SPARE_B4}) begin
      rd_val = spare_b4_q;
    end else if (rd_idx == {2'b00, `AECR_IDX_SPARE_B5}) begin
      rd_val = spare_b5_q;
    end else if (rd_idx == {2'b00, `AECR_IDX_PIXCNT_LO}) begin
      rd_val = stats.pix_count[15:0]; // RQ1
    end else if (rd_idx == {2'b00, `AECR_IDX_PIXCNT_HI}) begin
      rd_val = {13'h0000, stats.pix_count[18:16]}; // RQ2
    end else if (rd_idx == {2'b00, `AECR_IDX_MEAN}) begin
      rd_val = {3'h0, stats.locked, 2'h0, stats.mean_level}; // RQ3
    end else if (rd_idx == {2'b00, `AECR_IDX_INTEG}) begin
      rd_val = stats.integration;
    end else if (rd_idx == {2'b00, `AECR_IDX_AMP}) begin
      rd_val = {stats.digital_gain, stats.second_analog_amp_step,
                stats.first_analog_amp_step}; // RQ4
    end else if (rd_idx == {2'b00, `AECR_IDX_SPARE_BD}) begin
      rd_val = 16'h0000;
    end else if (rd_idx == {2'b00, `AECR_IDX_SEQ_CTRL}) begin
      rd_val = seq_ctrl_q;
    end else if (rd_idx == {2'b00, `AECR_IDX_MULT}) begin
      rd_val = mult_q;
    end else if (rd_idx == {2'b00, `AECR_IDX_EXPO_LEN}) begin
      rd_val = expo_len_q;
    end else if (rd_idx == {2'b00, `AECR_IDX_IRQ_STAT}) begin
      rd_val = {13'h0000, irq_stat_q};
    end else if (rd_idx == {2'b00, `AECR_IDX_IRQ_MASK}) begin
      rd_val = {13'h0000, irq_mask_q};
    end else begin
      rd_ok = 1'b0;
    end
  end

  // read channel: one outstanding read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `AECR_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= {16'h0000, rd_val};
        s_axi_rresp   <= rd_ok ? `AECR_RESP_OKAY : `AECR_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // pin synchronisers; change accepted when stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig_sync_q  <= 3'h0;
      fsync_sync_q <= 3'h0;
      trig_q       <= 1'b0;
      fsync_q      <= 1'b0;
    end else begin
      trig_sync_q  <= {trig_sync_q[1:0], trigger_pin};
      fsync_sync_q <= {fsync_sync_q[1:0], frame_sync_pin};
      if (trig_sync_q[1] == trig_sync_q[2]) begin
        trig_q <= trig_sync_q[2];
      end
      if (fsync_sync_q[1] == fsync_sync_q[2]) begin
        fsync_q <= fsync_sync_q[2];
      end
    end
  end

  logic trig_prev_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig_prev_q <= 1'b0;
    end else begin
      trig_prev_q <= trig_q;
    end
  end
  assign trig_rise = trig_q && !trig_prev_q;

  // exposure sequencer
  always_comb begin
    tmr_start = 1'b0;
    case (seq_q)
      aecr_pkg::AECR_SEQ_IDLE: begin
        tmr_start = mode.enable && !mode.rolling && !mode.triggered && !mode.slave;
      end
      aecr_pkg::AECR_SEQ_WAIT_TRIG: begin
        tmr_start = mode.enable && ((mode.triggered && trig_rise) ||
                                    (mode.slave && !mode.triggered && fsync_q));
      end
      default: begin
        tmr_start = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seq_q <= aecr_pkg::AECR_SEQ_IDLE;
    end else if (!mode.enable) begin
      seq_q <= aecr_pkg::AECR_SEQ_IDLE; // RQ5
    end else begin
      case (seq_q)
        aecr_pkg::AECR_SEQ_IDLE: begin
          if (tmr_start) begin
            seq_q <= aecr_pkg::AECR_SEQ_EXPOSE;
          end else if (!mode.rolling && (mode.triggered || mode.slave)) begin
            seq_q <= aecr_pkg::AECR_SEQ_WAIT_TRIG; // RQ7 RQ8
          end
        end
        aecr_pkg::AECR_SEQ_WAIT_TRIG: begin
          if (tmr_start) begin
            seq_q <= aecr_pkg::AECR_SEQ_EXPOSE;
          end else if (mode.rolling || !(mode.triggered || mode.slave)) begin
            seq_q <= aecr_pkg::AECR_SEQ_IDLE; // RQ11
          end
        end
        aecr_pkg::AECR_SEQ_EXPOSE: begin
          if (tmr_done) begin
            seq_q <= aecr_pkg::AECR_SEQ_IDLE;
          end
        end
        default: begin
          seq_q <= aecr_pkg::AECR_SEQ_IDLE;
        end
      endcase
    end
  end

  aecr_unit_timer u_timer (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .start       (tmr_start),
    .mult_cycles (mult_q),
    .units       (expo_len_q),
    .done        (tmr_done)
  );

  // mode outputs from flip-flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seq_running   <= 1'b0;
      seq_rolling   <= 1'b0;
      seq_triggered <= 1'b0;
      seq_slave     <= 1'b0;
      expose_active <= 1'b0;
    end else begin
      seq_running   <= mode.enable;    // RQ5
      seq_rolling   <= mode.rolling;   // RQ6
      seq_triggered <= mode.triggered; // RQ7 RQ11
      seq_slave     <= mode.slave;     // RQ8 RQ11
      expose_active <= (seq_q == aecr_pkg::AECR_SEQ_EXPOSE) && !tmr_done;
    end
  end

  // events: lock rise, exposure done, integration readback change
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_q  <= 1'b0;
      integ_q <= 16'h0000;
    end else begin
      lock_q  <= stats.locked;
      integ_q <= stats.integration;
    end
  end

  assign irq_evt[`AECR_IRQ_LOCK_BIT]     = stats.locked && !lock_q;
  assign irq_evt[`AECR_IRQ_EXPO_BIT]     = tmr_done;
  assign irq_evt[`AECR_IRQ_STAT_UPD_BIT] = stats.integration != integ_q;

  // set wins over write-one-to-clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_q <= '0;
      irq       <= 1'b0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_evt;
      irq        <= |(((irq_stat_q & ~irq_clr) | irq_evt) & irq_mask_q);
    end
  end

  chk_ctrl_reset_zero: assert property (@(posedge aclk)
    $rose(aresetn) |-> seq_ctrl_q[1:0] == 2'b00) // RQ5
    else $error("control bits not zero after reset");

  chk_idle_when_off: assert property (@(posedge aclk) disable iff (!aresetn)
    !mode.enable |=> seq_q == aecr_pkg::AECR_SEQ_IDLE) // RQ5
    else $error("sequencer left idle while disabled");

  chk_rolling_out: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 seq_rolling == $past(seq_ctrl_q[`AECR_SEQ_ROLLING_BIT])) // RQ6
    else $error("rolling output does not follow control bit 1");

  chk_trig_gated: assert property (@(posedge aclk) disable iff (!aresetn)
    seq_ctrl_q[`AECR_SEQ_ROLLING_BIT] |=> !seq_triggered) // RQ11
    else $error("triggered mode active with rolling shutter");

  chk_trig_global: assert property (@(posedge aclk) disable iff (!aresetn)
    (seq_ctrl_q[`AECR_SEQ_TRIG_BIT] && !seq_ctrl_q[`AECR_SEQ_ROLLING_BIT]) |=> seq_triggered) // RQ7
    else $error("triggered mode not taken in global shutter");

  chk_slave_global: assert property (@(posedge aclk) disable iff (!aresetn)
    (seq_ctrl_q[`AECR_SEQ_SLAVE_BIT] && !seq_ctrl_q[`AECR_SEQ_ROLLING_BIT]) |=> seq_slave) // RQ8
    else $error("slave mode not taken in global shutter");

  chk_pixcnt_high: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready && rd_idx == {2'b00, `AECR_IDX_PIXCNT_HI})
    |=> s_axi_rdata == {29'h0, $past(stats.pix_count[18:16])}) // RQ2
    else $error("pixel count high word wrong");

  chk_mean_read: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready && rd_idx == {2'b00, `AECR_IDX_MEAN})
    |=> s_axi_rdata[12] == $past(stats.locked) && s_axi_rdata[9:0] == $past(stats.mean_level)) // RQ3
    else $error("mean level word wrong");

  chk_ro_ignored: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_fire && wr_idx == {2'b00, `AECR_IDX_MEAN}) |=> $stable(seq_ctrl_q) && $stable(mult_q)) // RQ10
    else $error("write to status word changed state");

  chk_low_read: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready && rd_idx == {2'b00, `AECR_IDX_PIXCNT_LO})
    |=> s_axi_rdata[15:0] == $past(stats.pix_count[15:0])) // RQ1
    else $error("pixel count low word wrong");

  chk_gain_read: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready && rd_idx == {2'b00, `AECR_IDX_AMP})
    |=> s_axi_rdata[15:4] == $past(stats.digital_gain)) // RQ4
    else $error("digital gain readback wrong");

  chk_unit_len: assert property (@(posedge aclk) disable iff (!aresetn)
    (tmr_start && mult_q == 16'h0002 && expo_len_q == 16'h0003) |-> ##7 tmr_done) // RQ9
    else $error("exposure length not units times multiplier");

endmodule

/* File: core/aecr_unit_timer.sv */
// exposure timer: counts units of mult_cycles system clocks
// assumes a single clock domain and synchronous active-low reset
`timescale 1ns/100ps
`include "aecr_defines.svh"

module aecr_unit_timer (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        start,
  input  wire logic [15:0] mult_cycles,
  input  wire logic [15:0] units,
  output logic             done
);

  logic [15:0] cyc_q;
  logic [15:0] unit_q;
  logic        run_q;

  // one unit equals mult_cycles clock periods
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cyc_q  <= 16'h0000;
      unit_q <= 16'h0000;
      run_q  <= 1'b0;
      done   <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        cyc_q  <= 16'h0001;
        unit_q <= 16'h0000;
        run_q  <= 1'b1;
      end else if (run_q) begin
        if (cyc_q >= mult_cycles) begin // RQ9
          cyc_q <= 16'h0001;
          if (unit_q + 16'h0001 >= units) begin
            run_q <= 1'b0;
            done  <= 1'b1;
          end else begin
            unit_q <= unit_q + 16'h0001;
          end
        end else begin
          cyc_q <= cyc_q + 16'h0001;
        end
      end
    end
  end

endmodule

/* File: dv/aec_status_seq_config_regs_tb.sv */
// bench for the aec status and sequencer configuration register bank
// assumes aecr_regs as an axi4-lite slave on a single 40 MHz clock
`timescale 1ns/100ps
`include "aecr_defines.svh"

module aec_status_seq_config_regs_tb;
  logic                  aclk, aresetn;
  logic [11:0]           awaddr, araddr;
  logic                  awvalid, awready, wvalid, wready, bvalid, bready;
  logic                  arvalid, arready, rvalid, rready;
  logic [31:0]           wdata, rdata, rd, wdv;
  logic [3:0]            wstrb;
  logic [1:0]            bresp, rresp, rs;
  logic                  trig, fsync, run, roll, trg, slv, expo, irq;
  logic [63:0]           rnd;
  aecr_pkg::aecr_stats_s st;
  int                    err_total, compares, n;
  logic [7:0]            rv_ix [12] = '{`AECR_IDX_SPARE_B3, `AECR_IDX_SPARE_B4,
    `AECR_IDX_SPARE_B5, 8'hB8, 8'hB9, 8'hBA, 8'hBB, 8'hBC, 8'hBD, `AECR_IDX_SEQ_CTRL,
    `AECR_IDX_MULT, `AECR_IDX_EXPO_LEN};
  logic [15:0]           rv_val [12] = '{`AECR_RST_SPARE_B3, `AECR_RST_SPARE_B4,
    `AECR_RST_SPARE_B5, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, `AECR_RST_SEQ_CTRL,
    `AECR_RST_MULT, `AECR_RST_EXPO_LEN};
  logic [31:0]           m_ctl [4] = '{32'h11, 32'h21, 32'h13, 32'h23};

  aecr_regs DUT (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .stats(st), .trigger_pin(trig), .frame_sync_pin(fsync), .seq_running(run),
    .seq_rolling(roll), .seq_triggered(trg), .seq_slave(slv), .expose_active(expo), .irq(irq)
  );

  task automatic print_verdict();
    $display("errors=%0d compares=%0d", err_total, compares);
    if (err_total == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // ready seen at the falling edge is what the next rising edge samples
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic a, w, b;
    awaddr  <= {2'b00, idx, 2'b00};
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(negedge aclk);
      a = awvalid & awready;
      w = wvalid & wready;
      b = bvalid;
      rs = bresp;
      @(posedge aclk);
      if (a) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end
  endtask

  task automatic rchk(input logic [7:0] idx, input logic [31:0] e,
                      input logic [1:0] er = `AECR_RESP_OKAY);
    logic a, r;
    araddr  <= {2'b00, idx, 2'b00};
    arvalid <= 1'b1;
    r = 1'b0;
    while (!r) begin
      @(negedge aclk);
      a = arvalid & arready;
      r = rvalid;
      rd = rdata;
      rs = rresp;
      @(posedge aclk);
      if (a) arvalid <= 1'b0;
    end
    chk(rd, e);
    chk({30'h0, rs}, {30'h0, er});
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask

  task automatic wait_for(input logic lvl, input int lim, output int t);
    t = 0;
    @(negedge aclk);
    while (expo !== lvl && t < lim) begin
      t++;
      @(negedge aclk);
    end
    @(posedge aclk);
  endtask

  // reference view of the statistics words
  function automatic logic [31:0] stat_exp(input int k);
    case (k)
      0: return {16'h0, st.pix_count[15:0]};
      1: return {29'h0, st.pix_count[18:16]};
      2: return {19'h0, st.locked, 2'b00, st.mean_level};
      3: return {16'h0, st.integration};
      4: return {16'h0, st.digital_gain, st.second_analog_amp_step, st.first_analog_amp_step};
      default: return 32'h0;
    endcase
  endfunction

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  initial begin
    #(25 * 40000);
    err_total++;
    print_verdict();
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, trig, fsync} = 8'h14;
    {awaddr, araddr, wdata} = 56'h0;
    wstrb = 4'hF;
    st = '0;
    n = $urandom(32'h63F4);
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    foreach (rv_ix[i]) rchk(rv_ix[i], {16'h0, rv_val[i]});
    rchk(8'hB6, 32'h0, `AECR_RESP_SLVERR);
    wr(8'hB7, 32'h1);
    chk({30'h0, rs}, {30'h0, `AECR_RESP_SLVERR});
    for (int r = 0; r < 4; r++) begin
      rnd = {$urandom(), $urandom()};
      st <= rnd[61:0];
      for (int k = 0; k < 6; k++) begin
        wr(8'hB8 + k[7:0], ~rnd[31:0]);
        rchk(8'hB8 + k[7:0], stat_exp(k));
      end
    end
    for (int c = 0; c < 16; c++) begin
      rnd[31:0] = $urandom();
      wdv = {rnd[31:6], c[3], c[2], rnd[3:2], c[1], c[0]};
      wr(`AECR_IDX_SEQ_CTRL, wdv);
      cyc(2);
      rchk(`AECR_IDX_SEQ_CTRL, wdv & 32'h33);
      chk({28'h0, run, roll, trg, slv}, {28'h0, c[0], c[1], c[2] & !c[1], c[3] & !c[1]});
    end
    wr(`AECR_IDX_SEQ_CTRL, 32'h0);
    wr(`AECR_IDX_MULT, 32'h2);
    wr(`AECR_IDX_EXPO_LEN, 32'h3);
    cyc(20);
    wr(`AECR_IDX_IRQ_STAT, 32'h7);
    wr(`AECR_IDX_IRQ_MASK, 32'h2);
    cyc(2);
    chk({31'h0, irq}, 32'h0);
    wr(`AECR_IDX_SEQ_CTRL, 32'h1);
    wait_for(1'b1, 300, n);
    wait_for(1'b0, 300, n);
    chk(32'(n + 1), 32'd6);
    cyc(2);
    chk({31'h0, irq}, 32'h1);
    wr(`AECR_IDX_SEQ_CTRL, 32'h0);
    cyc(20);
    wr(`AECR_IDX_IRQ_MASK, 32'h0);
    cyc(2);
    chk({31'h0, irq}, 32'h0);
    rchk(`AECR_IDX_IRQ_STAT, 32'h2);
    wr(`AECR_IDX_IRQ_MASK, 32'h2);
    cyc(2);
    chk({31'h0, irq}, 32'h1);
    wr(`AECR_IDX_IRQ_STAT, 32'h2);
    cyc(2);
    chk({31'h0, irq}, 32'h0);
    foreach (m_ctl[i]) begin
      wr(`AECR_IDX_SEQ_CTRL, m_ctl[i]);
      wait_for(1'b1, 20, n);
      chk(32'(n), 32'd20);
      if (m_ctl[i][4]) trig <= 1'b1;
      else fsync <= 1'b1;
      wait_for(1'b1, 30, n);
      chk(32'(n < 30), {31'h0, !m_ctl[i][1]});
      trig  <= 1'b0;
      fsync <= 1'b0;
      wr(`AECR_IDX_SEQ_CTRL, 32'h0);
      cyc(20);
    end
    print_verdict();
  end
endmodule
